// File: design/usp_fifo_mem.sv
// Small receive character store with registered read data
`timescale 1ns/1ns
module usp_fifo_mem #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4,
  parameter int AW = 2
) (
  // Clock
  input wire logic clk_in,
  // Write side
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  // Read side
  input wire logic [AW-1:0] rd_addr_in,
  output logic [WIDTH-1:0] rd_data_out
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[rd_addr_in];
  end
endmodule

// File: design/usp_pkg.sv
// Register map, field positions, reset values and types for the serial port
package usp_pkg;
  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CR1 = 8'h04;
  localparam logic [7:0] OFS_CR2 = 8'h08;
  localparam logic [7:0] OFS_CR3 = 8'h0c;
  localparam logic [7:0] OFS_DATA = 8'h10;
  localparam logic [7:0] OFS_BRDH = 8'h14;
  localparam logic [7:0] OFS_BRDL = 8'h18;
  localparam logic [7:0] OFS_UFCR = 8'h1c;
  localparam logic [7:0] OFS_RXCNT = 8'h20;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int C1_ON = 7;
  localparam int C1_BNO = 6;
  localparam int C1_PAR = 5;
  localparam int C1_PRT = 3;
  localparam int C1_BRK = 2;
  localparam int C1_TX8 = 0;
  localparam int C2_TXON = 7;
  localparam int C2_RXON = 6;
  localparam int C2_STOP = 5;
  localparam int C2_ADDR = 4;
  localparam int C2_WAKE = 3;
  localparam int C2_RIE = 2;
  localparam int C2_TIIE = 1;
  localparam int C2_TEIE = 0;
  localparam int C3_SWM = 0;
  localparam int C3_MIRROR = 1;
  localparam int UF_FTR = 0;
  // ----------------------------------------
  // Reset values and encodings
  // ----------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] BRD_RST = 16'h0000;
  localparam logic [1:0] PRT_EVEN = 2'h0;
  localparam logic [1:0] PRT_ODD = 2'h1;
  localparam logic [1:0] PRT_MARK = 2'h2;
  localparam int RX_DEPTH_DEF = 4;
  localparam int FRAME_W = 13;
  localparam logic [3:0] BASE_LEN = 4'ha;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } usp_rx_t;
endpackage

// File: design/usp_top.sv
// Asynchronous serial port with single-wire mode and APB registers
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
// Overview of operation
// - Frame carries eight or nine data bits by configuration; both ends agree.
// - Parity is even, odd, mark, space or absent.
// - One or two stop bits by configuration.
// - Bit timing on both directions from a sixteen-bit divisor.
// - Receiver flags parity, framing, noise and overrun errors.
// - With address detect on, a last data bit of one marks an address.
// - Four-entry receive queue; one-entry transmit buffer ahead of shifter.
// - Requests for buffer empty, idle, receive full, overrun and address.
// - Transmitter and receiver enabled independently.
// - Enabled directions turn pins into output or input; transmit pull-up off.
// - Clearing port or transmit enable floats the affected pin; clearing receive enable in single-wire with transmit set makes the shared pin transmit.
// - Single-wire select makes one shared pin carry both directions.
// - Single-wire: shared pin receives if receive on, else transmits.
// - Single-wire with both enables set acts only as receiver.
// - Single-wire transmit may also appear on the dedicated output pin.
// - Written byte moves to shifter and goes out LSB first.
// - Received bits enter LSB first; complete character goes to queue.
// - Shift registers are not addressable; only data register is mapped.
// - One data address: writes fill transmit buffer, reads give oldest.
// - Activity on the receive pin can request wake-up.
// - Ninth bit held in receive bit and taken from transmit bit.
// - Disable empties buffers, resets baud count, clears flags, sets idles.
// - Status read then data access clears error and receive flags.
module usp_top import usp_pkg::*; #(
  parameter int RX_DEPTH = RX_DEPTH_DEF
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic resetn_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Serial pins
  output logic serial_out_pin_out,
  output logic serial_out_pin_oe_out,
  input wire logic serial_in_shared_pin_in,
  output logic serial_in_shared_pin_out,
  output logic serial_in_shared_pin_oe_out,
  output logic tx_pullup_off_out,
  // Requests
  output logic irq_out,
  output logic wake_out
);
  localparam int PW = $clog2(RX_DEPTH);
  localparam int CW = $clog2(RX_DEPTH + 1);

  if (RX_DEPTH < 2 || (RX_DEPTH & (RX_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("RX_DEPTH must be a power of two of at least two");
  end

  typedef struct packed {
    logic [7:0] cr1;
    logic [7:0] cr2;
    logic [7:0] cr3;
    logic [7:0] ufcr;
    logic [15:0] brd;
    logic perr;
    logic nf;
    logic ferr;
    logic oerr;
    logic addr_seen;
    logic txif;
    logic armed;
    logic [8:0] tx_buf;
    logic tx_full;
    logic [FRAME_W-1:0] tx_sh;
    logic [3:0] tx_left;
    logic [15:0] tx_cnt;
    usp_rx_t rx_st;
    logic [15:0] rx_cnt;
    logic [3:0] rx_idx;
    logic [9:0] rx_sh;
    logic rx_nz;
    logic [1:0] pin_sync;
    logic [2:0] hist;
    logic [PW-1:0] head;
    logic [PW-1:0] tail;
    logic [CW-1:0] count;
    logic wait_done;
    logic [31:0] prdata;
  } usp_state_t;

  usp_state_t s;
  usp_state_t next_s;
  logic [1:0] rst_pipe;
  logic rst_n;
  logic [8:0] head_data;
  logic push;
  logic rx_done;
  logic acc;
  logic on;
  logic tx_en;
  logic rx_en;
  logic tx_line;
  logic tidle;
  logic rxif;
  logic [15:0] per;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic par_of(logic [8:0] d, logic nine, logic [1:0] prt);
    logic x;
    x = ^d[7:0] ^ (nine & d[8]);
    unique case (prt)
      PRT_EVEN: par_of = x;
      PRT_ODD: par_of = ~x;
      PRT_MARK: par_of = 1'b1;
      default: par_of = 1'b0;
    endcase
  endfunction

  function automatic logic is_mapped(logic [7:0] a);
    is_mapped = (a[1:0] == 2'h0) && (a <= OFS_RXCNT);
  endfunction

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  usp_fifo_mem #(.WIDTH(9), .DEPTH(RX_DEPTH), .AW(PW)) u_rxq (
    .clk_in(mclk_in),
    .wr_en_in(push),
    .wr_addr_in(s.tail),
    .wr_data_in({s.rx_sh[8] & s.cr1[C1_BNO], s.rx_sh[7:0]}),
    .rd_addr_in(s.head),
    .rd_data_out(head_data)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [FRAME_W-1:0] f;
    logic [3:0] nbits;
    logic maj;
    logic nine;
    logic [7:0] rv;
    logic pop;
    f = '1;
    nbits = 4'h0;
    rv = 8'h00;
    pop = 1'b0;
    push = 1'b0;
    rx_done = 1'b0;
    next_s = s;
    on = s.cr1[C1_ON];
    nine = s.cr1[C1_BNO];
    rx_en = on & s.cr2[C2_RXON];
    tx_en = on & s.cr2[C2_TXON] & ~(s.cr3[C3_SWM] & s.cr2[C2_RXON]);
    per = (s.brd == 16'h0000) ? 16'h0001 : s.brd;
    tidle = s.txif & (s.tx_left == 4'h0);
    rxif = s.count > CW'(s.ufcr[UF_FTR+:2]);
    acc = psel_in & penable_in & s.wait_done;
    next_s.wait_done = psel_in & penable_in & ~s.wait_done;
    next_s.pin_sync = {s.pin_sync[0], serial_in_shared_pin_in};
    next_s.hist = {s.hist[1:0], s.pin_sync[1]};
    maj = (s.hist[0] & s.hist[1]) | (s.hist[1] & s.hist[2]) | (s.hist[0] & s.hist[2]);

    // Transmit shifter, one bit per divisor period
    if (s.tx_left != 4'h0) begin
      if (s.tx_cnt <= 16'h0001) begin
        next_s.tx_sh = {1'b1, s.tx_sh[FRAME_W-1:1]};
        next_s.tx_left = s.tx_left - 4'h1;
        next_s.tx_cnt = per;
      end else begin
        next_s.tx_cnt = s.tx_cnt - 16'h0001;
      end
    end else if (s.tx_full && tx_en) begin
      if (nine) begin
        f[9:0] = {s.tx_buf, 1'b0};
      end else begin
        f[8:0] = {s.tx_buf[7:0], 1'b0};
      end
      if (s.cr1[C1_PAR]) begin
        f[4'h9 + {3'h0, nine}] = par_of(s.tx_buf, nine, s.cr1[C1_PRT+:2]);
      end
      next_s.tx_sh = f;
      next_s.tx_left = BASE_LEN + {3'h0, nine} + {3'h0, s.cr1[C1_PAR]} + {3'h0, s.cr2[C2_STOP]};
      next_s.tx_cnt = per;
      next_s.tx_full = 1'b0;
      next_s.txif = 1'b1;
    end

    // Clear sequence first, so a character finishing now still sets its flags
    if (acc && paddr_in == OFS_DATA && s.armed) begin
      next_s.perr = 1'b0;
      next_s.nf = 1'b0;
      next_s.ferr = 1'b0;
      next_s.oerr = 1'b0;
      next_s.addr_seen = 1'b0;
      next_s.armed = 1'b0;
    end
    // Receiver, majority of three samples at mid-bit
    nbits = 4'h8 + {3'h0, nine} + {3'h0, s.cr1[C1_PAR]};
    if (s.rx_st != RX_IDLE && s.rx_cnt > 16'h0001) begin
      next_s.rx_cnt = s.rx_cnt - 16'h0001;
    end else begin
      next_s.rx_cnt = per;
      unique case (s.rx_st)
        RX_IDLE: begin
          if (rx_en && s.hist[1] && !s.hist[0]) begin
            next_s.rx_st = RX_START;
            next_s.rx_cnt = (per > 16'h0001) ? {1'b0, per[15:1]} : 16'h0001;
          end
        end
        RX_START: begin
          next_s.rx_st = maj ? RX_IDLE : RX_DATA;
          next_s.rx_idx = 4'h0;
          next_s.rx_sh = 10'h000;
          next_s.rx_nz = (|s.hist) & ~(&s.hist);
        end
        RX_DATA: begin
          next_s.rx_sh[s.rx_idx] = maj;
          next_s.rx_nz = s.rx_nz | ((|s.hist) & ~(&s.hist));
          next_s.rx_idx = s.rx_idx + 4'h1;
          if (s.rx_idx == nbits - 4'h1) begin
            next_s.rx_st = RX_STOP;
          end
        end
        RX_STOP: begin
          rx_done = 1'b1;
          next_s.rx_st = RX_IDLE;
          if (!nine) begin
            next_s.rx_sh[8] = 1'b0;
          end
          if (s.count == CW'(RX_DEPTH)) begin
            next_s.oerr = 1'b1;
          end else begin
            push = 1'b1;
            next_s.nf = next_s.nf | s.rx_nz;
            next_s.ferr = next_s.ferr | ~maj;
            next_s.perr = next_s.perr | (s.cr1[C1_PAR] & (s.rx_sh[nbits-4'h1] !=
              par_of(s.rx_sh[8:0] & {nine, 8'hff}, nine, s.cr1[C1_PRT+:2])));
            next_s.addr_seen = next_s.addr_seen | (s.cr2[C2_ADDR] & s.rx_sh[4'h7 + {3'h0, nine}]);
            next_s.tail = s.tail + PW'(1);
          end
        end
      endcase
    end
    if (!nine) begin
      next_s.rx_sh[9] = 1'b0;
    end
    if (s.rx_st == RX_DATA && s.rx_cnt <= 16'h0001 && s.rx_idx == nbits - 4'h1 && nbits < 4'ha) begin
      next_s.rx_sh[9] = 1'b0;
    end

    // Register reads captured in the first access cycle
    if (psel_in && penable_in && !s.wait_done && !pwrite_in) begin
      unique case (paddr_in)
        OFS_STATUS: rv = {s.perr, s.nf, s.ferr, s.oerr, s.rx_st == RX_IDLE, rxif, tidle, s.txif};
        OFS_CR1: rv = {s.cr1[7:2], head_data[8], s.cr1[C1_TX8]};
        OFS_CR2: rv = s.cr2;
        OFS_CR3: rv = s.cr3;
        OFS_DATA: rv = head_data[7:0];
        OFS_BRDH: rv = s.brd[15:8];
        OFS_BRDL: rv = s.brd[7:0];
        OFS_UFCR: rv = s.ufcr;
        OFS_RXCNT: rv = 8'(s.count);
        default: rv = 8'h00;
      endcase
      next_s.prdata = {24'h000000, rv};
    end

    // Register writes and the status-then-data clear sequence
    if (acc && pwrite_in) begin
      unique case (paddr_in)
        OFS_CR1: next_s.cr1 = pwdata_in[7:0];
        OFS_CR2: next_s.cr2 = pwdata_in[7:0];
        OFS_CR3: next_s.cr3 = {6'h00, pwdata_in[1:0]};
        OFS_BRDH: next_s.brd[15:8] = pwdata_in[7:0];
        OFS_BRDL: next_s.brd[7:0] = pwdata_in[7:0];
        OFS_UFCR: next_s.ufcr = {2'h0, pwdata_in[5:0]};
        OFS_DATA: begin
          if (on) begin
            next_s.tx_buf = {s.cr1[C1_TX8], pwdata_in[7:0]};
            next_s.tx_full = 1'b1;
            next_s.txif = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (acc && !pwrite_in && paddr_in == OFS_STATUS) begin
      next_s.armed = 1'b1;
    end
    if (acc && paddr_in == OFS_DATA) begin
      if (!pwrite_in && s.count != '0) begin
        pop = 1'b1;
        next_s.head = s.head + PW'(1);
      end
    end
    next_s.count = s.count + CW'(push) - CW'(pop);

    // Port disable clears the datapath, both enables and break but keeps the other configuration
    if (!on) begin
      next_s.cr2[C2_TXON] = 1'b0;
      next_s.cr2[C2_RXON] = 1'b0;
      next_s.cr1[C1_BRK] = 1'b0;
      next_s.perr = 1'b0;
      next_s.nf = 1'b0;
      next_s.ferr = 1'b0;
      next_s.oerr = 1'b0;
      next_s.addr_seen = 1'b0;
      next_s.armed = 1'b0;
      next_s.txif = 1'b1;
      next_s.tx_full = 1'b0;
      next_s.tx_left = 4'h0;
      next_s.tx_cnt = 16'h0000;
      next_s.rx_st = RX_IDLE;
      next_s.rx_cnt = 16'h0000;
      next_s.head = '0;
      next_s.tail = '0;
      next_s.count = '0;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.txif <= 1'b1;
      s.cr1 <= CTRL_RST;
      s.brd <= BRD_RST;
      s.tx_sh <= '1;
      s.pin_sync <= 2'h3;
      s.hist <= 3'h7;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Break holds the line low only while the shifter is idle
  assign tx_line = (s.tx_left != 4'h0) ? s.tx_sh[0] : ~s.cr1[C1_BRK];
  assign serial_out_pin_out = tx_line;
  assign serial_in_shared_pin_out = tx_line;
  assign serial_out_pin_oe_out = tx_en & (~s.cr3[C3_SWM] | s.cr3[C3_MIRROR]);
  assign serial_in_shared_pin_oe_out = tx_en & s.cr3[C3_SWM];
  assign tx_pullup_off_out = serial_out_pin_oe_out;
  assign wake_out = s.cr2[C2_WAKE] & ~s.pin_sync[1];
  assign irq_out = on & ((s.cr2[C2_TEIE] & s.txif) | (s.cr2[C2_TIIE] & tidle) |
    (s.cr2[C2_RIE] & ((rxif & ~s.cr2[C2_ADDR]) | s.oerr | s.addr_seen)));
  assign pready_out = psel_in & penable_in & s.wait_done;
  assign pslverr_out = pready_out & ~is_mapped(paddr_in);
  assign prdata_out = s.prdata;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n);

  off_floats_a: assert property (!s.cr1[C1_ON] |-> !serial_out_pin_oe_out && !serial_in_shared_pin_oe_out)
    else $error("pin driven while port is off");
  swm_priority_a: assert property (s.cr1[C1_ON] && s.cr3[C3_SWM] && s.cr2[C2_RXON] |-> !serial_in_shared_pin_oe_out)
    else $error("shared pin driven while receiving");
  swm_drive_a: assert property (on && s.cr3[C3_SWM] && s.cr2[C2_TXON] && !s.cr2[C2_RXON] |-> serial_in_shared_pin_oe_out)
    else $error("shared pin not driven in single-wire transmit");
  fifo_bound_a: assert property (s.count <= CW'(RX_DEPTH))
    else $error("receive queue count beyond depth");
  start_low_a: assert property (on && s.tx_left == 4'h0 ##1 s.tx_left != 4'h0 |-> !serial_out_pin_out)
    else $error("frame did not open with a low start bit");
  bit_hold_a: assert property (on && s.tx_left != 4'h0 && s.tx_cnt > 16'h0001 ##1 on |-> $stable(s.tx_left))
    else $error("bit advanced before its period ended");
  overrun_flag_a: assert property (rx_done && on && s.count == CW'(RX_DEPTH) |=> s.oerr && $stable(s.count))
    else $error("overrun not flagged");
  disable_reset_a: assert property (!s.cr1[C1_ON] |=> s.txif && s.count == '0 && !s.oerr && s.rx_st == RX_IDLE)
    else $error("disable did not clear the datapath");
  data_write_a: assert property (acc && pwrite_in && paddr_in == OFS_DATA && on |=> !s.txif && s.tx_full)
    else $error("data write did not fill the transmit buffer");
  clear_seq_a: assert property (acc && paddr_in == OFS_DATA && s.armed && on && !rx_done |=> !s.perr && !s.ferr && !s.nf)
    else $error("clear sequence left error flags set");

  tx_frame_c: cover property (s.tx_left == 4'h1 ##1 s.tx_left == 4'h0);
  rx_push_c: cover property (push);
  overrun_c: cover property (rx_done && s.count == CW'(RX_DEPTH));
  swm_tx_c: cover property (serial_in_shared_pin_oe_out && s.tx_left != 4'h0);
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the serial port
`timescale 1ns/1ns
module tb_top import usp_pkg::*;;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, tx_pin, tx_oe, sh_out, sh_oe, pu_off, irq, wake, peer_out, err;
  logic sel_shared = 1'b0;
  logic [7:0] q;
  logic [11:0] fr;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  // Shared pin resolves to whoever drives it
  wire logic sh_line = sh_oe ? sh_out : peer_out;
  // A released pin floats; the far end's pull-up then holds it high
  wire logic peer_in = sel_shared ? (sh_oe ? sh_out : 1'b1) : (tx_oe ? tx_pin : 1'b1);

  usp_top i_dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .serial_out_pin_out(tx_pin),
    .serial_out_pin_oe_out(tx_oe), .serial_in_shared_pin_in(sh_line),
    .serial_in_shared_pin_out(sh_out), .serial_in_shared_pin_oe_out(sh_oe),
    .tx_pullup_off_out(pu_off), .irq_out(irq), .wake_out(wake));
  usp_serial_peer i_peer (.clk_in(mclk_in), .line_in(peer_in), .line_out(peer_out));

  initial begin
    forever #50 mclk_in = ~mclk_in;
  end
  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      stop_test();
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic stop_test;
    $display("compares %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Wait for the last release edge to pass, then a full APB transfer
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk_in);
    penable <= 1'b1;
    @(posedge mclk_in);
    // No assumed wait count; only the hang guard ends this wait
    while (pready !== 1'b1) @(posedge mclk_in);
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk({4'h0, q}, {4'h0, e});
  endtask
  task automatic txwait;
    apb(1'b0, OFS_STATUS, 8'h00);
    while (q[1] !== 1'b1) apb(1'b0, OFS_STATUS, 8'h00);
  endtask
  task automatic send_tx(input int nb, input logic [7:0] d);
    fork
      i_peer.catch_frame(nb, fr);
      wr(OFS_DATA, d);
    join
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    chk({10'h0, tx_oe, sh_oe}, 12'h0);
    rd(OFS_STATUS, 8'h0b);
    rd(OFS_CR2, 8'h00);
    apb(1'b0, 8'h24, 8'h00);
    chk({11'h0, err}, 12'h1);
    wr(OFS_BRDH, 8'h00);
    wr(OFS_BRDL, 8'h08);
    wr(OFS_CR1, 8'h80);
    wr(OFS_CR2, 8'hc0);
    @(posedge mclk_in);
    chk({10'h0, tx_oe, pu_off}, 12'h3);
    send_tx(9, 8'ha5);
    chk(fr, 12'hfa5);
    txwait();
    rd(OFS_STATUS, 8'h0b);
    wr(OFS_CR2, 8'hc3);
    @(posedge mclk_in);
    chk({11'h0, irq}, 12'h1);
    $display("test regs_tx finished");
  endtask
  task automatic t_format;
    logic par;
    // Four ones: even and space give 0, odd and mark give 1
    for (int p = 0; p < 4; p++) begin
      par = (p == 1 || p == 2);
      wr(OFS_CR1, {3'b101, 2'(p), 3'b000});
      wr(OFS_CR2, {2'b11, 1'(p), 5'h00});
      // Second byte follows at once, so bit 10 shows a second stop or the next start
      fork
        i_peer.catch_frame(11, fr);
        begin
          wr(OFS_DATA, 8'h3c);
          wr(OFS_DATA, 8'h3c);
        end
      join
      chk(fr, {1'b1, 1'(p), 1'b1, par, 8'h3c});
      txwait();
    end
    wr(OFS_CR1, 8'hc0);
    wr(OFS_CR2, 8'hc0);
    send_tx(10, 8'h3c);
    chk(fr, 12'he3c);
    i_peer.send(12'h35a, 10);
    rd(OFS_CR1, 8'hc2);
    rd(OFS_DATA, 8'h5a);
    $display("test format finished");
  endtask
  task automatic t_rx;
    wr(OFS_CR1, 8'h80);
    for (int i = 0; i < 5; i++) i_peer.send(12'h110 + 12'(i), 9);
    rd(OFS_RXCNT, 8'h04);
    rd(OFS_STATUS, 8'h1f);
    for (int i = 0; i < 4; i++) rd(OFS_DATA, 8'h10 + 8'(i));
    rd(OFS_STATUS, 8'h0b);
    wr(OFS_CR1, 8'ha0);
    i_peer.send(12'h207, 10);
    rd(OFS_STATUS, 8'h8f);
    rd(OFS_DATA, 8'h07);
    rd(OFS_STATUS, 8'h0b);
    wr(OFS_CR1, 8'h80);
    i_peer.send(12'h055, 9);
    rd(OFS_STATUS, 8'h2f);
    rd(OFS_DATA, 8'h55);
    $display("test receive finished");
  endtask
  task automatic t_single;
    wr(OFS_CR3, 8'h01);
    wr(OFS_CR2, 8'h80);
    @(posedge mclk_in);
    chk({10'h0, tx_oe, sh_oe}, 12'h1);
    sel_shared = 1'b1;
    send_tx(9, 8'h81);
    chk(fr, 12'hf81);
    txwait();
    wr(OFS_CR3, 8'h03);
    sel_shared = 1'b0;
    send_tx(9, 8'h42);
    chk(fr, 12'hf42);
    txwait();
    wr(OFS_CR2, 8'hc0);
    @(posedge mclk_in);
    chk({11'h0, sh_oe}, 12'h0);
    i_peer.send(12'h1c3, 9);
    rd(OFS_DATA, 8'hc3);
    wr(OFS_CR3, 8'h00);
    $display("test single_wire finished");
  endtask
  task automatic t_events;
    wr(OFS_CR1, 8'hc0);
    wr(OFS_CR2, 8'hd4);
    i_peer.send(12'h221, 10);
    chk({11'h0, irq}, 12'h0);
    rd(OFS_DATA, 8'h21);
    i_peer.send(12'h321, 10);
    chk({11'h0, irq}, 12'h1);
    apb(1'b0, OFS_STATUS, 8'h00);
    rd(OFS_DATA, 8'h21);
    @(posedge mclk_in);
    chk({11'h0, irq}, 12'h0);
    wr(OFS_CR1, 8'h80);
    wr(OFS_CR2, 8'h48);
    fork
      i_peer.send(12'h1aa, 9);
      begin
        repeat (6) @(posedge mclk_in);
        chk({11'h0, wake}, 12'h1);
      end
    join
    i_peer.send(12'h177, 9);
    wr(OFS_CR1, 8'h84);
    @(posedge mclk_in);
    chk({11'h0, tx_pin}, 12'h0);
    wr(OFS_CR1, 8'h00);
    @(posedge mclk_in);
    chk({9'h0, tx_pin, tx_oe, sh_oe}, 12'h4);
    rd(OFS_STATUS, 8'h0b);
    rd(OFS_RXCNT, 8'h00);
    rd(OFS_CR2, 8'h08);
    rd(OFS_BRDL, 8'h08);
    $display("test events_disable finished");
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge mclk_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    t_regs();
    t_format();
    t_rx();
    t_single();
    t_events();
    stop_test();
  end
endmodule

// File: tb/usp_serial_peer.sv
// Far-end serial device model: frame sender and frame catcher
`timescale 1ns/1ns
module usp_serial_peer (
  // Clock
  input wire logic clk_in,
  // Serial line
  input wire logic line_in,
  output logic line_out
);
  // Bit length in cycles, kept equal to the port's divisor
  int bit_cyc = 8;
  // Line idles high; the model drives it high between frames
  initial line_out = 1'b1;
  // ----------------------------------------
  // Send: start bit, then nb bits from bit 0; caller gives stops
  // ----------------------------------------
  task automatic send(input logic [11:0] bits, input int nb);
    @(posedge clk_in);
    line_out <= 1'b0;
    repeat (bit_cyc) @(posedge clk_in);
    for (int i = 0; i < nb; i++) begin
      line_out <= bits[i];
      repeat (bit_cyc) @(posedge clk_in);
    end
    line_out <= 1'b1;
    repeat (bit_cyc) @(posedge clk_in);
  endtask
  // ----------------------------------------
  // Catch: find start, sample nb bits at mid-bit
  // ----------------------------------------
  task automatic catch_frame(input int nb, output logic [11:0] bits);
    // Only the bench's hang guard ends this wait
    bits = 12'hfff;
    while (line_in !== 1'b0) @(posedge clk_in);
    repeat (bit_cyc / 2) @(posedge clk_in);
    for (int i = 0; i < nb; i++) begin
      repeat (bit_cyc) @(posedge clk_in);
      bits[i] = line_in;
    end
  endtask
endmodule
